// ===== design/uabd_autobaud.sv
// auto-baud measurement unit with transmit gate, top module
//
// Notes on behaviour
// (RULE1) writing run bit starts; hardware clears on completion
// (RULE2) clearing run bit aborts measurement
// (RULE3) mode bit picks fall-to-fall or fall-to-rise
// (RULE4) restart bit: restart at next falling edge
// (RULE5) write one clears end interrupt flag
// (RULE6) write one clears time-out interrupt flag
// (RULE7) counter overflow sets time-out flag if enabled
// (RULE8) completion sets end flag after latch load
// (RULE9) run sets counter, shifter reset, fast timing
// (RULE10) falling edge starts prescaled counting
// (RULE11) sixteen shifter pulses during start bit
// (RULE12) stop edge loads latches, normal timing
// (RULE13) fractional divider register never modified
// (RULE14) software writes latches before starting; no latch write path here, the latches load only at the stop edge
// (RULE15) counter is fifteen bits wide
// (RULE16) sender supplies A or a character
// (RULE17) transmit gate enables transmission
// (RULE18) current character finishes, no further loads
// (RULE19) overflow without restart ends, latches unchanged
module uabd_autobaud (
  input  wire logic        sys_clk,          // peripheral clock, 20 MHz
  input  wire logic        rst_n,            // async reset, active low
  input  wire logic [31:0] regAddr,          // register byte address
  input  wire logic        regWrite,         // one-cycle write strobe
  input  wire logic        regRead,          // one-cycle read strobe
  input  wire logic [31:0] regWdata,         // write data
  output logic      [31:0] regRdata,         // read data, valid cycle after regRead
  input  wire logic        rxPin,            // receive pin
  input  wire logic        prescaleTick,     // fractional generator tick, high when disabled
  input  wire logic        endIrqEnable,     // end_irq_enable bit of irq_enable_reg
  input  wire logic        timeoutIrqEnable, // timeout_irq_enable bit of irq_enable_reg
  input  wire logic        txHoldValid,      // holding register or fifo has data
  input  wire logic        txShiftBusy,      // transmit shifter is sending
  output logic             txLoad,           // one-cycle move into shifter
  output logic      [7:0]  divisorLatchLow,  // divisor_latch_low value
  output logic      [7:0]  divisorLatchHigh, // divisor_latch_high value
  output logic             divisorLoad,      // one-cycle latch load strobe
  output logic             rxShifterReset,   // one-cycle shifter reset
  output logic             rxFastTiming,     // shifter runs at top rate
  output logic             rxBitPulse,       // bit-rate pulse for shifter
  output logic             endIrqFlag,       // end_irq_flag
  output logic             timeoutIrqFlag,   // timeout_irq_flag
  output logic             autobaudRunning   // run bit view
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  // two-flop release of the asynchronous reset
  logic [1:0] rstPipe_q;
  logic       rstSync_n;

  // release synchroniser; assertion is immediate
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe_q <= 2'b00;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end

  assign rstSync_n = rstPipe_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection

  logic rxFall;  // falling edge of rx
  logic rxRise;  // rising edge of rx

  uabd_edge_detect uEdge (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .pinIn     (rxPin),
    .fallPulse (rxFall),
    .risePulse (rxRise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    uabd_pkg::uabd_state_e                       state;
    logic                                        run;
    logic                                        mode;
    logic                                        restart;
    logic [uabd_pkg::RATE_COUNT_WIDTH-1:0]       count;
    logic [4:0]                                  pulses;
    logic                                        txEnable;
    logic [7:0]                                  dll;
    logic [7:0]                                  dlm;
    logic                                        divLoad;
    logic                                        endFlag;
    logic                                        toFlag;
    logic                                        shReset;
    logic                                        fast;
    logic                                        bitPulse;
    logic                                        txLoad;
    logic [31:0]                                 rdata;
  } uabd_regs_s;

  uabd_regs_s r_q;  // registered state
  uabd_regs_s r_d;  // next state

  // decoded accesses and events
  logic wrCtrl;
  logic wrGate;
  logic endEvent;
  logic toEvent;
  logic overflow;

  assign wrCtrl = regWrite && (regAddr == uabd_pkg::AUTOBAUD_CONTROL_ADDR);
  assign wrGate = regWrite && (regAddr == uabd_pkg::TRANSMIT_GATE_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // one process covers control, measurement, flags and transmit gate
  always_comb
  begin
    r_d          = r_q;
    r_d.divLoad  = 1'b0;
    r_d.shReset  = 1'b0;
    r_d.bitPulse = 1'b0;
    r_d.txLoad   = 1'b0;
    endEvent     = 1'b0;
    toEvent      = 1'b0;
    overflow     = prescaleTick && (&r_q.count);

    // control register write
    if (wrCtrl)
    begin
      r_d.mode    = regWdata[uabd_pkg::MODE_BIT];     // [RULE3]
      r_d.restart = regWdata[uabd_pkg::RESTART_BIT];  // [RULE4]
      if (regWdata[uabd_pkg::RUN_BIT])
      begin
        // arm: clear counter, reset shifter, fast timing  [RULE1] [RULE9]
        r_d.run     = 1'b1;
        r_d.state   = uabd_pkg::UABD_ARMED;
        r_d.count   = '0;
        r_d.pulses  = '0;
        r_d.shReset = 1'b1;
        r_d.fast    = 1'b1;
      end
      else
      begin
        // software abort leaves latches alone  [RULE2]
        r_d.run   = 1'b0;
        r_d.state = uabd_pkg::UABD_IDLE;
        r_d.fast  = 1'b0;
      end
    end
    else
    begin
      case (r_q.state)
        uabd_pkg::UABD_IDLE:
        begin
          r_d.run = 1'b0;
        end
        uabd_pkg::UABD_ARMED:
        begin
          // falling edge opens the start bit  [RULE10]
          if (rxFall)
          begin
            r_d.state  = uabd_pkg::UABD_COUNT;
            r_d.count  = '0;
            r_d.pulses = '0;
          end
        end
        uabd_pkg::UABD_COUNT:
        begin
          if ((r_q.mode && rxRise) || (!r_q.mode && rxFall))
          begin
            // stop edge: load latches, normal timing  [RULE3] [RULE12]
            r_d.dll     = r_q.count[7:0];
            r_d.dlm     = {1'b0, r_q.count[14:8]};
            r_d.divLoad = 1'b1;
            r_d.fast    = 1'b0;
            r_d.run     = 1'b0;          // [RULE1]
            r_d.state   = uabd_pkg::UABD_IDLE;
            endEvent    = endIrqEnable;  // [RULE8]
          end
          else if (prescaleTick)
          begin
            if (overflow)
            begin
              toEvent = timeoutIrqEnable;  // [RULE7]
              if (r_q.restart)
              begin
                // rearm for the next falling edge  [RULE4]
                r_d.state = uabd_pkg::UABD_WAITRST;
                r_d.count = '0;
              end
              else
              begin
                // give up; latches keep old value  [RULE19]
                r_d.state = uabd_pkg::UABD_IDLE;
                r_d.run   = 1'b0;
                r_d.fast  = 1'b0;
              end
            end
            else
            begin
              // 15-bit counter at the prescaled rate  [RULE10] [RULE15]
              r_d.count = r_q.count + 15'h0001;
            end
            // capture pulses during the start bit  [RULE11]
            if (r_q.pulses < uabd_pkg::START_PULSES)
            begin
              r_d.bitPulse = 1'b1;
              r_d.pulses   = r_q.pulses + 5'h01;
            end
          end
        end
        uabd_pkg::UABD_WAITRST:
        begin
          // restart waits for a fresh falling edge  [RULE4]
          if (rxFall)
          begin
            r_d.state   = uabd_pkg::UABD_COUNT;
            r_d.pulses  = '0;
            r_d.shReset = 1'b1;
          end
        end
        default:
        begin
          r_d.state = uabd_pkg::UABD_IDLE;
        end
      endcase
    end

    // flags: a control write suppresses the events, so a write-one clear wins  [RULE5] [RULE6]
    if (wrCtrl && regWdata[uabd_pkg::END_CLR_BIT])
      r_d.endFlag = 1'b0;
    if (wrCtrl && regWdata[uabd_pkg::TIMEOUT_CLR_BIT])
      r_d.toFlag = 1'b0;
    if (endEvent)
      r_d.endFlag = 1'b1;  // [RULE8]
    if (toEvent)
      r_d.toFlag = 1'b1;   // [RULE7]

    // transmit gate
    if (wrGate)
      r_d.txEnable = regWdata[uabd_pkg::TX_ENABLE_BIT];
    // only new loads are blocked; a busy shifter finishes  [RULE17] [RULE18]
    r_d.txLoad = r_q.txEnable && txHoldValid && !txShiftBusy && !r_q.txLoad;

    // read mux; clear bits read zero
    if (regRead && (regAddr == uabd_pkg::AUTOBAUD_CONTROL_ADDR))
      r_d.rdata = {29'h0000_0000, r_q.restart, r_q.mode, r_q.run};
    else if (regRead && (regAddr == uabd_pkg::TRANSMIT_GATE_ADDR))
      r_d.rdata = {24'h00_0000, r_q.txEnable, 7'h00};
    else
      r_d.rdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // the fractional divider is only an input tick here, never written  [RULE13]
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      r_q          <= '0;
      r_q.state    <= uabd_pkg::UABD_IDLE;
      {r_q.restart, r_q.mode, r_q.run} <= uabd_pkg::CONTROL_RESET;
      r_q.txEnable <= uabd_pkg::TX_ENABLE_RESET;
    end
    else
      r_q <= r_d;
  end

  // outputs straight from flops
  assign regRdata         = r_q.rdata;
  assign txLoad           = r_q.txLoad;
  assign divisorLatchLow  = r_q.dll;
  assign divisorLatchHigh = r_q.dlm;
  assign divisorLoad      = r_q.divLoad;
  assign rxShifterReset   = r_q.shReset;
  assign rxFastTiming     = r_q.fast;
  assign rxBitPulse       = r_q.bitPulse;
  assign endIrqFlag       = r_q.endFlag;
  assign timeoutIrqFlag   = r_q.toFlag;
  assign autobaudRunning  = r_q.run;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence armWrite;
    wrCtrl && regWdata[uabd_pkg::RUN_BIT];
  endsequence

  AST_ARM_SETS_RUN: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE1]
    armWrite |=> autobaudRunning && rxShifterReset && rxFastTiming)
    else $error("run write did not arm");

  AST_ABORT: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE2]
    wrCtrl && !regWdata[uabd_pkg::RUN_BIT] |=> !autobaudRunning && !divisorLoad)
    else $error("abort did not stop measurement");

  AST_LOAD_ENDS: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE12]
    divisorLoad |-> !autobaudRunning && !rxFastTiming)
    else $error("latch load without end of run");

  AST_END_FLAG: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE8]
    $rose(endIrqFlag) |-> divisorLoad)
    else $error("end flag without latch load");

  AST_END_CLR: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE5]
    wrCtrl && regWdata[uabd_pkg::END_CLR_BIT] && !endEvent |=> !endIrqFlag)
    else $error("end flag not cleared");

  AST_TO_CLR: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE6]
    wrCtrl && regWdata[uabd_pkg::TIMEOUT_CLR_BIT] && !toEvent |=> !timeoutIrqFlag)
    else $error("time-out flag not cleared");

  AST_TO_SET: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE7]
    toEvent |=> timeoutIrqFlag)
    else $error("time-out flag missing");

  AST_PULSES: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE11]
    r_q.pulses <= uabd_pkg::START_PULSES)
    else $error("too many capture pulses");

  AST_TX_GATE: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE18]
    txLoad |-> $past(r_q.txEnable))
    else $error("load while gate closed");

  // overflow while counting, with no stop edge and no control register write in the same cycle
  sequence overflowGiveUp;
    r_q.state == uabd_pkg::UABD_COUNT && overflow && !r_q.restart && !wrCtrl
      && !(r_q.mode ? rxRise : rxFall);
  endsequence

  sequence overflowRearm;
    r_q.state == uabd_pkg::UABD_COUNT && overflow && r_q.restart && !wrCtrl
      && !(r_q.mode ? rxRise : rxFall);
  endsequence

  AST_GIVE_UP: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE19]
    overflowGiveUp |=> !autobaudRunning && !rxFastTiming && !divisorLoad)
    else $error("overflow without restart did not stop");

  AST_REARM: assert property (@(posedge sys_clk) disable iff (!rstSync_n) // [RULE4]
    overflowRearm |=> autobaudRunning && rxFastTiming && !divisorLoad)
    else $error("overflow with restart did not rearm");

endmodule

// ===== design/uabd_edge_detect.sv
// falling and rising edge detector for the receive pin
module uabd_edge_detect (
  input  wire logic sys_clk,
  input  wire logic rstSync_n,
  input  wire logic pinIn,
  output logic      fallPulse,
  output logic      risePulse
);

  // one flop history of the pin; idle line is high
  logic pinPrev_q;

  // sample history
  always_ff @(posedge sys_clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      pinPrev_q <= 1'b1;
    else
      pinPrev_q <= pinIn;
  end

  // edges are combinational from the previous sample
  assign fallPulse = pinPrev_q & ~pinIn;
  assign risePulse = ~pinPrev_q & pinIn;

endmodule

// ===== design/uabd_pkg.sv
// package: register offsets, field positions, reset values and timing counts of the auto-baud unit
package uabd_pkg;

  // register byte addresses as printed
  localparam logic [31:0] AUTOBAUD_CONTROL_ADDR = 32'hE000_C020;
  localparam logic [31:0] TRANSMIT_GATE_ADDR    = 32'hE000_C030;

  // control and transmit gate field positions
  localparam int RUN_BIT        = 0;
  localparam int MODE_BIT       = 1;
  localparam int RESTART_BIT    = 2;
  localparam int END_CLR_BIT    = 8;
  localparam int TIMEOUT_CLR_BIT = 9;
  localparam int TX_ENABLE_BIT  = 7;

  // reset values
  localparam logic [2:0]  CONTROL_RESET = 3'h0;
  localparam logic        TX_ENABLE_RESET = 1'b1;

  // counter width and start-bit capture pulses
  localparam int          RATE_COUNT_WIDTH = 15;
  localparam logic [4:0]  START_PULSES     = 5'h10;

  // measurement states
  typedef enum logic [1:0] {
    UABD_IDLE    = 2'b00,
    UABD_ARMED   = 2'b01,
    UABD_COUNT   = 2'b10,
    UABD_WAITRST = 2'b11
  } uabd_state_e;

endpackage

// ===== verification/tb_top.sv
// self-checking testbench of the auto-baud unit and transmit gate
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CTRL = uabd_pkg::AUTOBAUD_CONTROL_ADDR;
  localparam logic [31:0] GATE = uabd_pkg::TRANSMIT_GATE_ADDR;
  logic        sys_clk = 1'b0;  // 20 MHz clock
  logic        rst_n = 1'b0;    // async reset, active low
  logic [31:0] regAddr = 32'h0000_0000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata, rd;
  logic        rxPin, busy, go = 1'b0;
  logic [7:0]  chr = 8'h00;
  logic [3:0]  nBits = 4'h8;
  logic [15:0] bitCycles = 16'h0014;
  logic        endIrqEnable = 1'b1;
  logic        timeoutIrqEnable = 1'b1;
  logic        prescaleTick = 1'b1;  // stands in for the fractional generator's tick
  logic        halfRate = 1'b0;      // tick on every second clock while set
  logic        txHoldValid = 1'b0;
  logic        txShiftBusy = 1'b0;
  logic        txLoad, divisorLoad, rxShifterReset, rxFastTiming, rxBitPulse;
  logic        endIrqFlag, timeoutIrqFlag, autobaudRunning;
  logic [7:0]  divisorLatchLow, divisorLatchHigh;
  int          nErrors = 0, checks = 0, cyc = 0;
  int          pulseCnt = 0, loadCnt = 0, rstCnt = 0, txCnt = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #25 sys_clk = ~sys_clk;
  uabd_sender_model peer (.sys_clk(sys_clk), .go(go), .chr(chr), .nBits(nBits),
    .bitCycles(bitCycles), .rxPin(rxPin), .busy(busy));
  // the tick is high on every clock unless a scenario asks for half rate
  uabd_autobaud dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .rxPin(rxPin), .prescaleTick(prescaleTick), .endIrqEnable(endIrqEnable),
    .timeoutIrqEnable(timeoutIrqEnable), .txHoldValid(txHoldValid),
    .txShiftBusy(txShiftBusy), .txLoad(txLoad), .divisorLatchLow(divisorLatchLow),
    .divisorLatchHigh(divisorLatchHigh), .divisorLoad(divisorLoad),
    .rxShifterReset(rxShifterReset), .rxFastTiming(rxFastTiming), .rxBitPulse(rxBitPulse),
    .endIrqFlag(endIrqFlag), .timeoutIrqFlag(timeoutIrqFlag),
    .autobaudRunning(autobaudRunning));
  ////////////////////////////////////////////////////////////////////////////////
  // pulse counters and tick; the whole run needs about 74k cycles, so 90k means a hang
  always @(posedge sys_clk)
  begin
    cyc++;
    // half rate restarts its phase at each frame request, so the count is fixed
    prescaleTick <= (halfRate && !go) ? ~prescaleTick : 1'b1;
    pulseCnt += (rxBitPulse === 1'b1);
    loadCnt += (divisorLoad === 1'b1);
    rstCnt += (rxShifterReset === 1'b1);
    txCnt += (txLoad === 1'b1);
    if (cyc == 90000)
    begin
      nErrors++;
      $display("ERROR watchdog expected finish seen hang");
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write held for one edge, then one idle edge so its effect has landed
  task automatic regWr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic regRd(input logic [31:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic send(input logic [7:0] c, input logic [3:0] n, input logic [15:0] len);
    @(posedge sys_clk);
    chr <= c;
    nBits <= n;
    bitCycles <= len;
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // latches are never written before arming, so their prior value cannot matter
  task automatic t_measure(input logic [7:0] c, input logic mode, input logic [15:0] len,
                           input logic [15:0] expCount, input logic en, input logic half);
    endIrqEnable <= en;
    halfRate <= half;
    pulseCnt = 0;
    loadCnt = 0;
    rstCnt = 0;
    regWr(CTRL, {30'h0, mode, 1'b1});
    chk("running", 1, autobaudRunning);
    chk("fast timing", 1, rxFastTiming);
    send(c, 4'h8, len);
    chk("divisor", expCount, {divisorLatchHigh, divisorLatchLow});
    chk("running after", 0, autobaudRunning);
    chk("fast after", 0, rxFastTiming);
    chk("end flag", en, endIrqFlag);
    chk("bit pulses", 16, pulseCnt);
    chk("latch loads", 1, loadCnt);
    chk("shifter resets", 1, rstCnt);
    regRd(CTRL, rd);
    chk("control read", {30'h0, mode, 1'b0}, rd);
    regWr(CTRL, 32'h0000_0000);
    chk("end flag kept", en, endIrqFlag);
    regWr(CTRL, 32'h0000_0100);
    chk("end flag cleared", 0, endIrqFlag);
    halfRate <= 1'b0;
  endtask
  // clearing the run bit in mid-count must leave the latches alone
  task automatic t_abort();
    loadCnt = 0;
    regWr(CTRL, 32'h0000_0001);
    fork
      send(8'h41, 4'h8, 16'h0014);
      begin
        repeat (12) @(posedge sys_clk);
        regWr(CTRL, 32'h0000_0000);
      end
    join
    chk("abort running", 0, autobaudRunning);
    chk("abort loads", 0, loadCnt);
    chk("abort latches", 16'h0013, {divisorLatchHigh, divisorLatchLow});
  endtask
  // nine low bit times (32814 cycles) overflow the 15-bit counter; first with restart clear
  task automatic t_timeout();
    loadCnt = 0;
    timeoutIrqEnable <= 1'b0;
    regWr(CTRL, 32'h0000_0001);
    send(8'h00, 4'h8, 16'h0E3E);
    chk("masked timeout flag", 0, timeoutIrqFlag);
    chk("stopped on overflow", 0, autobaudRunning);
    chk("fast after overflow", 0, rxFastTiming);
    chk("latches kept", 16'h0013, {divisorLatchHigh, divisorLatchLow});
    timeoutIrqEnable <= 1'b1;
    regWr(CTRL, 32'h0000_0005);
    send(8'h00, 4'h8, 16'h0E3E);
    chk("timeout flag", 1, timeoutIrqFlag);
    chk("still running", 1, autobaudRunning);
    chk("no load on overflow", 0, loadCnt);
    send(8'h41, 4'h8, 16'h0014);
    chk("restart divisor", 16'h0027, {divisorLatchHigh, divisorLatchLow});
    regWr(CTRL, 32'h0000_0200);
    chk("timeout cleared", 0, timeoutIrqFlag);
  endtask
  // gate open loads, busy shifter or closed gate blocks further loads
  task automatic t_txgate();
    regRd(GATE, rd);
    chk("gate reset", 32'h0000_0080, rd & 32'h0000_0080);
    txHoldValid <= 1'b1;
    txCnt = 0;
    repeat (6) @(posedge sys_clk);
    chk("tx loads open", 1, txCnt > 0);
    txShiftBusy <= 1'b1;
    @(posedge sys_clk);
    #1;
    txCnt = 0;
    repeat (6) @(posedge sys_clk);
    chk("tx loads busy", 0, txCnt);
    txShiftBusy <= 1'b0;
    regWr(GATE, 32'h0000_0000);
    txCnt = 0;
    repeat (6) @(posedge sys_clk);
    chk("tx loads closed", 0, txCnt);
    regWr(GATE, 32'h0000_0080);
    txCnt = 0;
    repeat (6) @(posedge sys_clk);
    chk("tx loads reopened", 1, txCnt > 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    regRd(CTRL, rd);
    chk("control reset", 32'h0000_0000, rd);
    regRd(32'hE000_C024, rd);
    chk("unmapped read", 32'h0000_0000, rd);
    $display("test reset done");
    t_measure(8'h41, 1'b0, 16'h0014, 16'h0027, 1'b1, 1'b0);
    $display("test fall to fall done");
    t_measure(8'h61, 1'b1, 16'h0018, 16'h0017, 1'b0, 1'b0);
    $display("test start bit only done");
    t_measure(8'h61, 1'b1, 16'h0028, 16'h0013, 1'b1, 1'b1);
    $display("test prescaled count done");
    t_abort();
    $display("test abort done");
    t_timeout();
    $display("test overflow restart done");
    t_txgate();
    $display("test transmit gate done");
    give_verdict();
  end
endmodule

// ===== verification/uabd_sender_model.sv
// remote serial sender model that drives the receive pin of the auto-baud unit
module uabd_sender_model (
  input  wire logic        sys_clk,   // peripheral clock
  input  wire logic        go,        // one-cycle frame request
  input  wire logic [7:0]  chr,       // character to send
  input  wire logic [3:0]  nBits,     // data bits in the frame
  input  wire logic [15:0] bitCycles, // clock cycles per bit
  output logic             rxPin,     // serial line, idles at mark
  output logic             busy       // frame in progress
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////////
  // line idles high, the pull-up level of a released serial line
  initial
  begin
    rxPin = 1'b1;
    busy  = 1'b0;
  end
  // start bit, data lsb first, then one stop bit; an 'A' or 'a' has its first two falls two bit times apart
  always @(posedge sys_clk)
  begin
    if (go)
    begin
      busy <= 1'b1;
      for (int i = 0; i <= nBits + 1; i++)
      begin
        rxPin <= (i == 0) ? 1'b0 : ((i > nBits) ? 1'b1 : chr[i-1]);
        repeat (bitCycles) @(posedge sys_clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
